/* File: shared/scd_pkg.sv */
// Constants for the sampling-clock delay and timestamp block: register map, fields, reset values and ramp timing.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses; all fields sit in byte lane 0 except the status busy and overflow bits 8 and 9.
// Notes on behaviour
// - Sample LSB carries converter data unless the stamp marker enable is set.
// - Stamp on: 12-bit sample is upper 11 converter bits plus trigger marker LSB.
// - Trigger marker passes a 1-bit path delayed to match converter core latency.
// - In 8-bit sample modes the marker sits in the 8-bit sample LSB.
// - Trigger marker may be asynchronous; it is synchronised and sampled with the input.
// - Timestamp is forced off whenever a decimating link format mode is selected.
// - Dual-channel mode samples each input once per clock on the rising edge.
// - Single-channel mode samples on both clock edges, two samples per clock.
// - One device clock drives sampling, digital processing and serializer outputs.
// - Clock inversion delay control inverts input clock, half-period sampling delay.
// - Three independent delays: half-period inversion, 256 coarse, 256 fine settings.
// - Applied aperture delay shifts every internal clock, link timing and reference capture.
// - Delays may change on the fly; ramping lowers the risk of link upset.
// - Ramping steps applied coarse delay gradually toward each newly written value.
// - Ramp rate: slow one step per 256 clocks, fast four steps per 256.
// - Ramp enable turns ramping on; each coarse write then starts a new ramp.
package scd_pkg;
    localparam int          SAMPLE_W      = 12;
    localparam int          LANE_W        = 2 * SAMPLE_W;
    localparam int          FIFO_DEPTH    = 8;
    localparam int          MARK_DLY      = 4;
    localparam int          ADR_W         = 8;
    localparam int          DELAY_W       = 8;

    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_TAD      = 8'h04;
    localparam logic [7:0]  ADDR_COARSE   = 8'h08;
    localparam logic [7:0]  ADDR_FINE     = 8'h0c;
    localparam logic [7:0]  ADDR_STATUS   = 8'h10;

    localparam int          CTRL_TS_EN    = 0;
    localparam int          CTRL_DUAL     = 1;
    localparam int          CTRL_DECIM    = 2;
    localparam int          CTRL_BIT8     = 3;
    localparam int          DLY_INV       = 0;
    localparam int          DLY_RAMP_EN   = 1;
    localparam int          DLY_RAMP_FAST = 2;
    localparam int          ST_BUSY       = 8;
    localparam int          ST_OVF        = 9;

    localparam logic [3:0]  CTRL_RST      = 4'h2;
    localparam logic [2:0]  TAD_RST       = 3'h0;
    localparam logic [7:0]  DELAY_RST     = 8'h00;

    // 256 clocks per ramp period; fast rate takes a step every quarter period.
    localparam logic [7:0]  SLOW_TICK     = 8'hff;
    localparam logic [5:0]  FAST_TICK     = 6'h3f;
endpackage : scd_pkg

/* File: hdl/scd_top.sv */
// Sampling-clock delay control, ramp engine, timestamp marker insertion and sample FIFO.
// Assumes one device clock, a classic Wishbone master, and a converter core that presents
// two 12-bit samples per clock with their own fixed latency already applied.
`timescale 1ns/1ps

module scd_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,    // Device clock.
    input  wire logic             rst_i,    // Synchronous reset, active high.
    input  wire logic             in_valid_i, // Write request.
    output logic                  in_ready_o, // Not full.
    input  wire logic [WIDTH-1:0] in_data_i,  // Write data.
    output logic                  out_valid_o, // Not empty.
    input  wire logic             out_ready_i, // Reader takes a word.
    output logic [WIDTH-1:0]      out_data_o   // Head word.
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [CW-1:0]    count_q;
    logic [CW-1:0]    count_d;
    logic             room_q;
    logic             avail_q;
    logic             push;
    logic             pop;

    // Flags are kept in the sense of the ports, so both handshake outputs come straight from flops.
    assign push        = in_valid_i && room_q;
    assign pop         = out_ready_i && avail_q;
    assign in_ready_o  = room_q;
    assign out_valid_o = avail_q;
    assign out_data_o  = mem_q[rd_ptr_q];

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + CW'(1);
        end else if (pop && !push) begin
            count_d = count_q - CW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= '0;
            room_q  <= 1'b1;
            avail_q <= 1'b0;
        end else begin
            count_q <= count_d;
            room_q  <= (count_d != CW'(DEPTH));
            avail_q <= (count_d != '0);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + PW'(1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + PW'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end
endmodule : scd_fifo

module scd_top #(
    parameter int MARK_LAT = scd_pkg::MARK_DLY,
    parameter int DEPTH    = scd_pkg::FIFO_DEPTH
) (
    input  wire logic                        clk_i,            // Device clock, the only clock.
    input  wire logic                        rst_i,            // Synchronous reset, active high.
    input  wire logic                        wb_cyc_i,         // Wishbone cycle.
    input  wire logic                        wb_stb_i,         // Wishbone strobe.
    input  wire logic                        wb_we_i,          // Wishbone write.
    input  wire logic [scd_pkg::ADR_W-1:0]   wb_adr_i,         // Byte address.
    input  wire logic [3:0]                  wb_sel_i,         // Byte enables.
    input  wire logic [31:0]                 wb_dat_i,         // Write data.
    output logic      [31:0]                 wb_dat_o,         // Read data.
    output logic                             wb_ack_o,         // Acknowledge.
    input  wire logic                        core_valid_i,     // Core samples present.
    input  wire logic [scd_pkg::SAMPLE_W-1:0] core_rise_i,     // Rising-edge sample or channel A.
    input  wire logic [scd_pkg::SAMPLE_W-1:0] core_fall_i,     // Falling-edge sample or channel B.
    output logic                             core_ready_o,     // Sample buffer has room.
    input  wire logic                        trigger_marker_i, // Asynchronous trigger.
    output logic                             smp_valid_o,      // Link word available.
    input  wire logic                        smp_ready_i,      // Link takes word.
    output logic [scd_pkg::LANE_W-1:0]       smp_data_o,       // Two formatted samples.
    output logic                             dual_channel_o,   // Sample on rising edge only.
    output logic                             clk_invert_o,     // Half-period inversion.
    output logic [scd_pkg::DELAY_W-1:0]      coarse_delay_o,   // Applied coarse delay.
    output logic [scd_pkg::DELAY_W-1:0]      fine_delay_o      // Applied fine delay.
);
    import scd_pkg::*;

    logic [3:0]          ctrl_q;
    logic [2:0]          tad_q;
    logic [DELAY_W-1:0]  target_q;
    logic [DELAY_W-1:0]  coarse_q;
    logic [DELAY_W-1:0]  fine_q;
    logic [7:0]          ramp_cnt_q;
    logic                ovf_q;
    logic                ack_q;
    logic [31:0]         dat_q;
    logic [31:0]         rd_d;
    logic                req;
    logic                wr_en;
    logic                coarse_wr;
    logic                step_tick;
    logic                ts_act;
    logic                sync1_q;
    logic                sync2_q;
    logic [MARK_LAT-1:0] mark_pipe_q;
    logic                mark_al;
    logic                fmt_valid_q;
    logic [LANE_W-1:0]   fmt_q;
    logic                fifo_in_ready;

    // Everything here runs from the device clock; there is no second domain.
    assign req       = wb_cyc_i && wb_stb_i;
    assign wr_en     = req && wb_we_i && ack_q && wb_sel_i[0];
    assign coarse_wr = wr_en && (wb_adr_i == ADDR_COARSE);
    assign wb_ack_o  = ack_q;
    assign wb_dat_o  = dat_q;

    // Ack follows a request by one cycle; writes land on the edge that the master sees ack.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    always_comb begin
        rd_d = 32'h0;
        case (wb_adr_i)
            ADDR_CTRL:   rd_d[3:0] = ctrl_q;
            ADDR_TAD:    rd_d[2:0] = tad_q;
            ADDR_COARSE: rd_d[DELAY_W-1:0] = target_q;
            ADDR_FINE:   rd_d[DELAY_W-1:0] = fine_q;
            ADDR_STATUS: begin
                rd_d[DELAY_W-1:0] = coarse_q;
                rd_d[ST_BUSY]     = (coarse_q != target_q);
                rd_d[ST_OVF]      = ovf_q;
            end
            default:     rd_d = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0;
        end else if (req && !ack_q) begin
            dat_q <= rd_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
            tad_q  <= TAD_RST;
            fine_q <= DELAY_RST;
        end else if (wr_en) begin
            if (wb_adr_i == ADDR_CTRL) begin
                ctrl_q <= wb_dat_i[3:0];
            end
            if (wb_adr_i == ADDR_TAD) begin
                tad_q <= wb_dat_i[2:0];
            end
            if (wb_adr_i == ADDR_FINE) begin
                fine_q <= wb_dat_i[DELAY_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            target_q <= DELAY_RST;
        end else if (coarse_wr) begin
            target_q <= wb_dat_i[DELAY_W-1:0];
        end
    end

    // The ramp period restarts on every coarse write so a new ramp gets full spacing.
    always_ff @(posedge clk_i) begin
        if (rst_i || coarse_wr) begin
            ramp_cnt_q <= 8'h00;
        end else begin
            ramp_cnt_q <= ramp_cnt_q + 8'h01;
        end
    end

    assign step_tick = tad_q[DLY_RAMP_FAST] ? (ramp_cnt_q[5:0] == FAST_TICK)
                                            : (ramp_cnt_q == SLOW_TICK);

    // Single steps avoid large jumps in the internal clock path that could upset the link.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            coarse_q <= DELAY_RST;
        end else if (coarse_wr && !tad_q[DLY_RAMP_EN]) begin
            coarse_q <= wb_dat_i[DELAY_W-1:0];
        end else if (tad_q[DLY_RAMP_EN] && step_tick && coarse_q != target_q) begin
            coarse_q <= (coarse_q < target_q) ? coarse_q + 8'h01 : coarse_q - 8'h01;
        end
    end

    // The three delays are independent and drive the whole clock tree of the device.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_invert_o   <= 1'b0;
            coarse_delay_o <= DELAY_RST;
            fine_delay_o   <= DELAY_RST;
            dual_channel_o <= CTRL_RST[CTRL_DUAL];
        end else begin
            clk_invert_o   <= tad_q[DLY_INV];
            coarse_delay_o <= coarse_q;
            fine_delay_o   <= fine_q;
            dual_channel_o <= ctrl_q[CTRL_DUAL];
        end
    end

    // Two-stage synchroniser for the asynchronous trigger.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= trigger_marker_i;
            sync2_q <= sync1_q;
        end
    end

    // A 1-bit delay line standing in for the converter core latency.
    generate
        for (genvar i = 0; i < MARK_LAT; i++) begin : g_mark
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    mark_pipe_q[i] <= 1'b0;
                end else begin
                    mark_pipe_q[i] <= (i == 0) ? sync2_q : mark_pipe_q[(i == 0) ? 0 : i - 1];
                end
            end
        end
    endgenerate
    assign mark_al = mark_pipe_q[MARK_LAT-1];

    assign ts_act = ctrl_q[CTRL_TS_EN] && !ctrl_q[CTRL_DECIM];

    function automatic logic [SAMPLE_W-1:0] fmt_lane(input logic [SAMPLE_W-1:0] s,
                                                     input logic mk, input logic act, input logic b8);
        if (!act) begin
            return s;
        end
        if (b8) begin
            return {s[SAMPLE_W-1:5], mk, 4'h0};
        end
        return {s[SAMPLE_W-1:1], mk};
    endfunction : fmt_lane

    // Dual mode carries channel B in the upper lane; single mode carries the falling-edge sample.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fmt_valid_q <= 1'b0;
            fmt_q       <= '0;
        end else begin
            fmt_valid_q <= core_valid_i;
            fmt_q       <= {fmt_lane(core_fall_i, mark_al, ts_act, ctrl_q[CTRL_BIT8]),
                            fmt_lane(core_rise_i, mark_al, ts_act, ctrl_q[CTRL_BIT8])};
        end
    end

    // The core cannot stop; a word offered while the buffer is full is lost and flagged.
    // Set wins over a write-one clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovf_q <= 1'b0;
        end else if (fmt_valid_q && !fifo_in_ready) begin
            ovf_q <= 1'b1;
        end else if (wr_en && wb_adr_i == ADDR_STATUS && wb_dat_i[ST_OVF]) begin
            ovf_q <= 1'b0;
        end
    end

    scd_fifo #(
        .WIDTH (LANE_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (fmt_valid_q),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fmt_q),
        .out_valid_o (smp_valid_o),
        .out_ready_i (smp_ready_i),
        .out_data_o  (smp_data_o)
    );
    assign core_ready_o = fifo_in_ready;

    property p_ts_off;
        @(posedge clk_i) disable iff (rst_i)
        !ts_act |=> fmt_q[SAMPLE_W-1:0] == $past(core_rise_i);
    endproperty
    a_ts_off: assert property (p_ts_off) else $error("Sample altered with timestamp off.");

    property p_ts_on;
        @(posedge clk_i) disable iff (rst_i)
        ts_act && !ctrl_q[CTRL_BIT8] |=> fmt_q[0] == $past(mark_al) && fmt_q[11:1] == $past(core_rise_i[11:1]);
    endproperty
    a_ts_on: assert property (p_ts_on) else $error("Marker not in sample LSB.");

    property p_mark_lat;
        @(posedge clk_i) disable iff (rst_i)
        mark_al == $past(trigger_marker_i, MARK_LAT + 2);
    endproperty
    a_mark_lat: assert property (p_mark_lat) else $error("Marker latency wrong.");

    property p_ts_8bit;
        @(posedge clk_i) disable iff (rst_i)
        ts_act && ctrl_q[CTRL_BIT8] |=> fmt_q[4] == $past(mark_al) && fmt_q[16] == $past(mark_al);
    endproperty
    a_ts_8bit: assert property (p_ts_8bit) else $error("Marker not in 8-bit LSB.");

    property p_decim;
        @(posedge clk_i) disable iff (rst_i)
        ctrl_q[CTRL_DECIM] |=> fmt_q[SAMPLE_W-1:0] == $past(core_rise_i);
    endproperty
    a_decim: assert property (p_decim) else $error("Timestamp active in decimation.");

    property p_fall_lane;
        @(posedge clk_i) disable iff (rst_i)
        !ts_act |=> fmt_q[LANE_W-1:SAMPLE_W] == $past(core_fall_i);
    endproperty
    a_fall_lane: assert property (p_fall_lane) else $error("Second sample lane wrong.");

    property p_inv;
        @(posedge clk_i) disable iff (rst_i)
        wr_en && wb_adr_i == ADDR_TAD |=> ##1 clk_invert_o == $past(wb_dat_i[DLY_INV], 2);
    endproperty
    a_inv: assert property (p_inv) else $error("Inversion output not updated.");

    property p_ramp_step;
        @(posedge clk_i) disable iff (rst_i)
        coarse_q != $past(coarse_q) && $past(tad_q[DLY_RAMP_EN]) && !$past(coarse_wr)
            |-> $past(step_tick) && (coarse_q - $past(coarse_q) == 8'h01 || $past(coarse_q) - coarse_q == 8'h01);
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("Ramp step off its tick or size.");

    property p_fast_ramp;
        @(posedge clk_i) disable iff (rst_i)
        coarse_wr && tad_q[DLY_RAMP_EN] && tad_q[DLY_RAMP_FAST] && wb_dat_i[7:0] != coarse_q
            ##1 tad_q[DLY_RAMP_EN] && tad_q[DLY_RAMP_FAST] [*8] |-> ##[56:57] coarse_q != $past(coarse_q);
    endproperty
    a_fast_ramp: assert property (p_fast_ramp) else $error("Fast ramp missed its first step.");

    property p_direct;
        @(posedge clk_i) disable iff (rst_i)
        coarse_wr && !tad_q[DLY_RAMP_EN] |=> coarse_q == $past(wb_dat_i[DELAY_W-1:0]);
    endproperty
    a_direct: assert property (p_direct) else $error("Direct coarse write not applied.");
endmodule : scd_top

/* File: test/scd_sink.sv */
// Downstream link receiver model for the sample stream of the timing block.
// Assumes the same device clock and a synchronous active-high reset.
`timescale 1ns/1ps

module scd_sink #(
    parameter int REF_R = 1, // Link ratio R of the reference rate.
    parameter int REF_F = 1, // Octets per frame F.
    parameter int REF_K = 4, // Frames per multiframe K.
    parameter int REF_N = 1  // Any positive divider n.
) (
    input  wire logic        clk_i,       // Device clock.
    input  wire logic        rst_i,       // Synchronous reset, active high.
    input  wire logic        stall_i,     // Bench asks the receiver to hold off.
    input  wire logic        smp_valid_i, // Word offered by the block.
    input  wire logic [23:0] smp_data_i,  // Offered word.
    output logic             smp_ready_o, // Receiver takes a word.
    output logic [23:0]      word_o,      // Last word taken.
    output logic [15:0]      count_o,     // Words taken since reset.
    input  wire logic        ref_once_i,  // Allow only the first reference pulse since reset instead of a periodic clock.
    output logic             ref_o        // System timing reference pulse.
);
    localparam int REF_PER = 10 * REF_F * REF_K * REF_N / REF_R;

    logic [23:0] word_q;
    logic [15:0] count_q;
    logic [15:0] ref_cnt_q;
    logic        ref_sent_q;
    logic        ref_wrap;

    assign ref_wrap = (ref_cnt_q == 16'(REF_PER - 1));

    // A real receiver may stall for long stretches, so readiness follows the bench.
    assign smp_ready_o = ~stall_i;
    assign word_o      = word_q;
    assign count_o     = count_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= 16'h0000;
            word_q  <= 24'h000000;
        end else if (smp_valid_i && smp_ready_o) begin
            count_q <= count_q + 16'h0001;
            word_q  <= smp_data_i;
        end
    end

    // The period is 10*F*K*n/R device clocks, so the reference divides the multiframe rate.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_cnt_q  <= 16'h0000;
            ref_sent_q <= 1'b0;
            ref_o      <= 1'b0;
        end else begin
            ref_cnt_q  <= ref_wrap ? 16'h0000 : ref_cnt_q + 16'h0001;
            ref_o      <= ref_wrap && !(ref_once_i && ref_sent_q);
            ref_sent_q <= ref_sent_q || ref_wrap;
        end
    end
endmodule : scd_sink

/* File: test/test_scd_top.sv */
// Self-checking bench for the sampling-clock delay and timestamp block.
// Assumes the sink model beside it and the package constants of the design.
`timescale 1ns/1ps

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end

module test_scd_top;
    import scd_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat_o;
    logic        ack_o, cvalid = 1'b0, cready_o, trig = 1'b0, svalid_o, sready, stall = 1'b0;
    logic [11:0] rise = 12'h000, fall = 12'h000;
    logic [23:0] sdata_o, sword;
    logic [15:0] scount;
    logic        ref_once = 1'b0, ref_p;
    logic        dual_o, inv_o;
    logic [7:0]  coarse_o, fine_o;
    logic [31:0] rd;
    int          n_errors = 0;
    int          num_checks = 0;

    always #12.5 clk_i = ~clk_i;

    scd_top #(.MARK_LAT(4), .DEPTH(8)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat_o), .wb_ack_o(ack_o),
        .core_valid_i(cvalid), .core_rise_i(rise), .core_fall_i(fall), .core_ready_o(cready_o),
        .trigger_marker_i(trig), .smp_valid_o(svalid_o), .smp_ready_i(sready), .smp_data_o(sdata_o),
        .dual_channel_o(dual_o), .clk_invert_o(inv_o), .coarse_delay_o(coarse_o), .fine_delay_o(fine_o));

    scd_sink sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .smp_valid_i(svalid_o),
        .smp_data_i(sdata_o), .smp_ready_o(sready), .word_o(sword), .count_o(scount),
        .ref_once_i(ref_once), .ref_o(ref_p));

    task automatic complete_run();
        if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    // One classic cycle; read data is taken at the edge that sees ack.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        r = rdat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (n >= 20) begin n_errors++; complete_run(); end
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, rd);
        `CHK(rd, e)
    endtask : rd_chk

    task automatic waitc(input int c);
        repeat (c) @(posedge clk_i);
    endtask : waitc

    task automatic reset_and_map();
        rd_chk(ADDR_CTRL, 32'h00000002);
        rd_chk(ADDR_TAD, 32'h00000000);
        rd_chk(ADDR_COARSE, 32'h00000000);
        rd_chk(ADDR_FINE, 32'h00000000);
        rd_chk(ADDR_STATUS, 32'h00000000);
        wr(8'h14, 32'h000000ff);
        rd_chk(8'h14, 32'h00000000);
        rd_chk(ADDR_CTRL, 32'h00000002);
        `CHK(dual_o, 1'b1)
    endtask : reset_and_map

    // Sends one pair with the marker held long enough to cross the synchroniser and delay line.
    task automatic ts_case(input logic [3:0] ctrl, input logic mk);
        logic        on;
        logic [23:0] e;
        int          n;
        on = ctrl[CTRL_TS_EN] & ~ctrl[CTRL_DECIM];
        wr(ADDR_CTRL, {28'h0, ctrl});
        trig <= mk;
        waitc(12);
        n = scount;
        rise <= 12'hab5; fall <= 12'h5a3; cvalid <= 1'b1;
        @(posedge clk_i);
        cvalid <= 1'b0;
        e = {12'h5a3, 12'hab5};
        if (on && !ctrl[CTRL_BIT8]) e = {11'h2d1, mk, 11'h55a, mk};
        if (on && ctrl[CTRL_BIT8]) e = {7'h2d, mk, 4'h0, 7'h55, mk, 4'h0};
        for (int i = 0; i < 30 && scount == n; i++) @(posedge clk_i);
        if (scount == n) begin
            n_errors++;
            complete_run();
        end
        `CHK(sword, e)
    endtask : ts_case

    task automatic delays_and_modes();
        wr(ADDR_CTRL, 32'h00000000);
        wr(ADDR_TAD, 32'h00000001);
        wr(ADDR_FINE, 32'h000000a5);
        waitc(3);
        `CHK(dual_o, 1'b0)
        `CHK(inv_o, 1'b1)
        `CHK(fine_o, 8'ha5)
        wr(ADDR_COARSE, 32'h00000003);
        waitc(2);
        `CHK(coarse_o, 8'h03)
        `CHK(inv_o, 1'b1)
    endtask : delays_and_modes

    task automatic ramp();
        wr(ADDR_TAD, 32'h00000006);
        wr(ADDR_COARSE, 32'h00000007);
        waitc(50);
        `CHK(coarse_o, 8'h03)
        rd_chk(ADDR_STATUS, 32'h00000103);
        waitc(50);
        `CHK(coarse_o, 8'h04)
        waitc(200);
        `CHK(coarse_o, 8'h07)
        wr(ADDR_TAD, 32'h00000002);
        wr(ADDR_COARSE, 32'h00000006);
        waitc(200);
        `CHK(coarse_o, 8'h07)
        waitc(100);
        `CHK(coarse_o, 8'h06)
        rd_chk(ADDR_STATUS, 32'h00000006);
    endtask : ramp

    // Fills the buffer past full with the receiver stalled, then drains it in order.
    task automatic fill_drain();
        int k;
        wr(ADDR_CTRL, 32'h00000000);
        stall <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            rise <= 12'h100 + 12'(i); fall <= 12'h200 + 12'(i); cvalid <= 1'b1;
        end
        @(posedge clk_i);
        cvalid <= 1'b0;
        waitc(4);
        `CHK(cready_o, 1'b0)
        `CHK(svalid_o, 1'b1)
        rd_chk(ADDR_STATUS, 32'h00000206);
        stall <= 1'b0;
        k = 0;
        for (int i = 0; i < 30; i++) begin
            @(posedge clk_i);
            if (svalid_o === 1'b1 && sready === 1'b1) begin
                `CHK(sdata_o, {12'h200 + 12'(k), 12'h100 + 12'(k)})
                k++;
            end
        end
        `CHK(k, 8)
        `CHK(svalid_o, 1'b0)
        `CHK(cready_o, 1'b1)
        wr(ADDR_STATUS, 32'h00000200);
        rd_chk(ADDR_STATUS, 32'h00000006);
    endtask : fill_drain

    // A 400-cycle window holds exactly ten periodic references, and none once single-pulse mode is on.
    task automatic ref_rate();
        int p;
        p = 0;
        repeat (400) begin
            @(posedge clk_i);
            if (ref_p === 1'b1) p++;
        end
        `CHK(p, 10)
        ref_once <= 1'b1;
        @(posedge clk_i);
        p = 0;
        repeat (400) begin
            @(posedge clk_i);
            if (ref_p === 1'b1) p++;
        end
        `CHK(p, 0)
    endtask : ref_rate

    initial begin
        waitc(3);
        rst_i <= 1'b0;
        reset_and_map();
        ts_case(4'h0, 1'b0);
        ts_case(4'h1, 1'b1);
        ts_case(4'h1, 1'b0);
        ts_case(4'h9, 1'b1);
        ts_case(4'h9, 1'b0);
        ts_case(4'h5, 1'b0);
        ts_case(4'h3, 1'b1);
        delays_and_modes();
        ramp();
        fill_drain();
        ref_rate();
        complete_run();
    end
endmodule : test_scd_top
